// *** common/adc_ctrl_defines.vh ***
// Purpose: constants for the converter control block
// Assumes: APB, 32-bit data, one register per aligned word
// Notes:   printed offsets are byte registers of an 8-bit space, kept as indices
`ifndef ADC_CTRL_DEFINES_VH
`define ADC_CTRL_DEFINES_VH

// ----------------------------------------
// register indices (byte address = 4 * index)
// ----------------------------------------
`define IDX_CLK_PRESCALER  8'hF2
`define IDX_CONTROL        8'hF3
`define IDX_RESULT_LOW     8'hF4
`define IDX_RESULT_HIGH    8'hF5
`define IDX_PIN_CONFIG     8'hF6
`define IDX_IRQ_ENABLE     8'hF7

// ----------------------------------------
// control fields
// ----------------------------------------
`define CTL_CHAN_LO        0
`define CTL_CHAN_HI        2
`define CTL_START          3
`define CTL_DONE           4
`define CTL_ENABLE         5
`define CTL_PSEUDO_IDLE_SELECT         6
`define IRQ_EN_BIT         1
`define PRS_W              5

// ----------------------------------------
// timing
// ----------------------------------------
`define ZERO_DIVIDE        8'd64
`define SAMPLE_CLOCKS      4'd1
`define CONV_CLOCKS        4'd11
`define FULL_SCALE         10'h3FF
`define ZERO_SCALE         10'h000
`define CODE_W             10
`define TRIAL_MSB          10'h200
`define STD_DROP_FROM      4'd9
`define TOP_BIT            4'd10

`endif

// *** hw/adc_conversion_control.v ***
// Purpose: control logic of an eight-input, ten-bit conversion unit
// Assumes: pclk is the peripheral clock; analog core gives comparator bit
// Notes:   successive approximation, msb first, one bit per converter clock
//
// Our own choices: the APB interface to the registers and the placing of the registers.
`include "adc_ctrl_defines.vh"

module adc_conversion_control (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire        compare_above,
   input  wire        other_irq_req,
   output reg  [2:0]  selected_analog_input,
   output reg  [7:0]  analog_pin_config_out,
   output reg         sample_hold,
   output reg  [9:0]  trial_code,
   output reg         converter_powered,
   output reg         cpu_halt,
   output reg         conv_irq,
   output reg         other_irq_out
);

// ----------------------------------------
// state
// ----------------------------------------
localparam [2:0] ST_IDLE   = 3'b001;
localparam [2:0] ST_SAMPLE = 3'b010;
localparam [2:0] ST_CONV   = 3'b100;

reg [2:0]          state;
reg [2:0]          channel_select;
reg                conv_start_busy;
reg                conv_done_flag;
reg                converter_enable;
reg                pseudo_idle_select;
reg                conv_irq_enable;
reg [`PRS_W-1:0]   clock_divider_setting;
reg [7:0]          analog_pin_config;
reg [7:0]          result_high_byte;
reg [1:0]          result_low_byte;
reg [7:0]          div_count;
reg [3:0]          bit_count;
reg [9:0]          sar;
reg                precision_run;
reg                cmp_meta;
reg                cmp_sync;
reg                irq_meta;
reg                irq_sync;

// ----------------------------------------
// decode
// ----------------------------------------
function hit;
   input [11:0] a;
   input [7:0]  idx;
   begin
      hit = (a[11:2] == {2'b00, idx}) && (a[1:0] == 2'b00);
   end
endfunction

wire        access  = psel & penable;
wire        wr      = access & pwrite;
wire        wr_ctl  = wr & hit(paddr, `IDX_CONTROL);
wire        busy    = (state != ST_IDLE);
// a start is taken only when idle, enabled and on an analog pin
// the same write must keep enable set, or standby would meet a running start
wire        start_ok = wr_ctl & pwdata[`CTL_START] & ~busy & converter_enable & pwdata[`CTL_ENABLE]
                       & analog_pin_config[pwdata[`CTL_CHAN_HI:`CTL_CHAN_LO]];

// prescaler: zero means divide by 64, else by twice the setting
wire [7:0]  div_top = (clock_divider_setting == {`PRS_W{1'b0}}) ? `ZERO_DIVIDE - 8'd1
                      : {2'b00, clock_divider_setting, 1'b0} - 8'd1;
wire        adc_tick = (div_count == 8'd0);
wire        last_bit = (bit_count == `CONV_CLOCKS - 4'd1);
// standard mode keeps eight bits; the two lsbs are not resolved
wire        keep_bit = pseudo_idle_select | (bit_count < `STD_DROP_FROM);
wire [3:0]  bit_pos  = `TOP_BIT - bit_count;
wire        finish   = (state == ST_CONV) & adc_tick & last_bit;
wire [9:0]  final_code = (cmp_sync & keep_bit) ? sar : (sar & ~(10'h001 << bit_pos[3:0]));

// ----------------------------------------
// synchronisers
// ----------------------------------------
always @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      cmp_meta <= 1'b0;
      cmp_sync <= 1'b0;
      irq_meta <= 1'b0;
      irq_sync <= 1'b0;
   end else begin
      cmp_meta <= compare_above;
      cmp_sync <= cmp_meta;
      irq_meta <= other_irq_req;
      irq_sync <= irq_meta;
   end
end

// ----------------------------------------
// conversion sequencer
// ----------------------------------------
always @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      state            <= ST_IDLE;
      div_count        <= 8'd0;
      bit_count        <= 4'd0;
      sar              <= `ZERO_SCALE;
      conv_start_busy  <= 1'b0;
      conv_done_flag   <= 1'b0;
      result_high_byte <= 8'h00;
      result_low_byte  <= 2'b00;
      precision_run    <= 1'b0;
   end else begin
      div_count <= (adc_tick | ~busy) ? div_top : div_count - 8'd1;
      // software clear of done flag; a same-cycle set below wins
      if (wr_ctl && !pwdata[`CTL_DONE])
         conv_done_flag <= 1'b0;
      case (state)
         ST_IDLE: begin
            if (start_ok) begin
               state           <= ST_SAMPLE;
               conv_start_busy <= 1'b1;
               bit_count       <= 4'd0;
               sar             <= `ZERO_SCALE;
               precision_run   <= pwdata[`CTL_PSEUDO_IDLE_SELECT];
            end
         end
         ST_SAMPLE: begin
            if (adc_tick) begin
               state     <= ST_CONV;
               bit_count <= `SAMPLE_CLOCKS;
               sar       <= `TRIAL_MSB;
            end
         end
         ST_CONV: begin
            if (adc_tick) begin
               if (last_bit) begin
                  // comparator saturates: input above reference leaves all ones, 3FC in standard mode
                  state            <= ST_IDLE;
                  conv_start_busy  <= 1'b0;
                  conv_done_flag   <= 1'b1;
                  result_high_byte <= final_code[9:2];
                  result_low_byte  <= final_code[1:0];
                  precision_run    <= 1'b0;
               end else begin
                  sar       <= final_code | (10'h001 << (bit_pos[3:0] - 4'd1));
                  bit_count <= bit_count + 4'd1;
               end
            end
         end
         default: state <= ST_IDLE;
      endcase
      // standby cuts a running conversion; it posts no result unless finishing now
      if (wr_ctl && !pwdata[`CTL_ENABLE] && busy) begin
         state           <= ST_IDLE;
         conv_start_busy <= 1'b0;
         precision_run   <= 1'b0;
      end
   end
end

// ----------------------------------------
// software registers
// ----------------------------------------
always @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      channel_select        <= 3'd0;
      converter_enable      <= 1'b0;
      pseudo_idle_select    <= 1'b0;
      conv_irq_enable       <= 1'b0;
      clock_divider_setting <= {`PRS_W{1'b0}};
      analog_pin_config     <= 8'h00;
   end else if (wr) begin
      // channel and mode are frozen while converting so the result stays coherent
      if (hit(paddr, `IDX_CONTROL) && !busy) begin
         channel_select     <= pwdata[`CTL_CHAN_HI:`CTL_CHAN_LO];
         pseudo_idle_select <= pwdata[`CTL_PSEUDO_IDLE_SELECT];
      end
      if (hit(paddr, `IDX_CONTROL))
         converter_enable <= pwdata[`CTL_ENABLE];
      if (hit(paddr, `IDX_CLK_PRESCALER))
         clock_divider_setting <= pwdata[`PRS_W-1:0];
      if (hit(paddr, `IDX_PIN_CONFIG))
         analog_pin_config <= pwdata[7:0];
      if (hit(paddr, `IDX_IRQ_ENABLE))
         conv_irq_enable <= pwdata[`IRQ_EN_BIT];
   end
end

// ----------------------------------------
// apb answer, zero wait states
// ----------------------------------------
always @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
   end else begin
      pready  <= psel & ~penable;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
      if (psel && !penable) begin
         if (hit(paddr, `IDX_CONTROL))
            prdata[7:0] <= {1'b0, pseudo_idle_select, converter_enable, conv_done_flag,
                            conv_start_busy, channel_select};
         else if (hit(paddr, `IDX_CLK_PRESCALER))
            prdata[`PRS_W-1:0] <= clock_divider_setting;
         else if (hit(paddr, `IDX_RESULT_HIGH))
            prdata[7:0] <= result_high_byte;
         else if (hit(paddr, `IDX_RESULT_LOW))
            prdata[1:0] <= result_low_byte;
         else if (hit(paddr, `IDX_PIN_CONFIG))
            prdata[7:0] <= analog_pin_config;
         else if (hit(paddr, `IDX_IRQ_ENABLE))
            prdata[`IRQ_EN_BIT] <= conv_irq_enable;
         else
            pslverr <= 1'b1;
      end
   end
end

// ----------------------------------------
// pins to the analog core and cpu
// ----------------------------------------
always @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      selected_analog_input <= 3'd0;
      analog_pin_config_out <= 8'h00;
      sample_hold           <= 1'b0;
      trial_code            <= `ZERO_SCALE;
      converter_powered     <= 1'b0;
      cpu_halt              <= 1'b0;
      conv_irq              <= 1'b0;
      other_irq_out         <= 1'b0;
   end else begin
      selected_analog_input <= channel_select;
      analog_pin_config_out <= analog_pin_config;
      sample_hold           <= (state == ST_SAMPLE);
      trial_code            <= sar;
      converter_powered     <= converter_enable;
      // halt only while a precision conversion runs; done flag wakes the cpu
      cpu_halt              <= precision_run & ~finish;
      conv_irq              <= conv_irq_enable & (conv_done_flag | finish);
      // other requests held back until the precision conversion ends
      other_irq_out         <= irq_sync & ~(precision_run & ~finish);
   end
end

endmodule

// *** tb/analog_source_model.sv ***
// Purpose: eight external analog sources seen through the channel mux
// Assumes: level is in code steps, 11 bits, above 3FF means above reference
// Notes:   half-step offset, so a level sitting on a code converts to it
module analog_source_model (
   input  wire [7:0][10:0] source_level,
   input  wire [2:0]       selected_analog_input,
   input  wire [9:0]       trial_code,
   output logic            compare_above
);
   // mux, then compare against the trial code with saturation above range
   assign compare_above = {source_level[selected_analog_input], 1'b1} > {1'b0, trial_code, 1'b0};
endmodule

// *** tb/adc_conversion_control_chk.sv ***
// Purpose: port-level checks of the converter control block
// Assumes: zero-wait APB slave, one clock domain
// Notes:   halt bound covers the slowest prescaler setting
module adc_conversion_control_chk (
   input wire        pclk,
   input wire        presetn,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [31:0] prdata,
   input wire        pready,
   input wire        pslverr,
   input wire [2:0]  selected_analog_input,
   input wire        sample_hold,
   input wire        converter_powered,
   input wire        cpu_halt,
   input wire        conv_irq,
   input wire        other_irq_out
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_ready_access: assert property (psel && penable |-> pready) else $error("no pready in access");
   a_ready_pulse: assert property (pready |=> !pready) else $error("pready longer than one cycle");
   a_ready_cause: assert property (pready |-> psel && penable) else $error("pready outside access");
   a_err_read: assert property (pslverr && !pwrite |-> pready && prdata == 32'h0) else $error("bad error read");
   a_standby_quiet: assert property (!converter_powered |-> !cpu_halt && !sample_hold) else $error("busy in standby");
   a_halt_bound: assert property ($rose(cpu_halt) |-> ##[1:900] !cpu_halt) else $error("halt too long");
   a_halt_gates: assert property (cpu_halt [*2] |-> !other_irq_out) else $error("irq during halt");
   a_chan_hold: assert property (cpu_halt && $past(cpu_halt) |-> $stable(selected_analog_input))
      else $error("channel moved while busy");
   cover property ($rose(cpu_halt));
   cover property ($rose(conv_irq));
   cover property (pslverr);
   cover property ($fell(converter_powered));
endmodule

bind adc_conversion_control adc_conversion_control_chk adc_conversion_control_chk_inst (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .selected_analog_input(selected_analog_input),
   .sample_hold(sample_hold), .converter_powered(converter_powered), .cpu_halt(cpu_halt),
   .conv_irq(conv_irq), .other_irq_out(other_irq_out));

// *** tb/adc_conversion_control_tb.sv ***
// Purpose: register-level tests of the converter control block
// Assumes: prescaler 3 gives a 6-cycle converter clock
// Notes:   bus answers taken at the rising edge, pin outputs on the falling edge
module adc_conversion_control_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk, presetn, psel, penable, pwrite, compare_above, other_irq_req;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic pready, pslverr, sample_hold, converter_powered, cpu_halt, conv_irq, other_irq_out;
   logic [2:0] selected_analog_input;
   logic [7:0] analog_pin_config_out;
   logic [9:0] trial_code;
   logic [7:0] sh_run = 8'h00;
   logic [7:0] sh_len = 8'h00;
   logic [31:0] d;
   logic [7:0][10:0] lvl = {11'h301, 11'h0F6, 11'h123, 11'h3FF, 11'h2AB, 11'h155, 11'h000, 11'h7FF};
   int err_total = 0;
   int total_checks = 0;
   logic se;

   adc_conversion_control adc_conversion_control_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .compare_above(compare_above), .other_irq_req(other_irq_req),
      .selected_analog_input(selected_analog_input), .analog_pin_config_out(analog_pin_config_out),
      .sample_hold(sample_hold), .trial_code(trial_code), .converter_powered(converter_powered),
      .cpu_halt(cpu_halt), .conv_irq(conv_irq), .other_irq_out(other_irq_out));
   analog_source_model analog_source_model_inst (.source_level(lvl), .trial_code(trial_code),
      .selected_analog_input(selected_analog_input), .compare_above(compare_above));

   // sample period length, in pclk cycles
   always @(posedge pclk) begin
      if (sample_hold)
         sh_run <= sh_run + 8'h01;
      else if (sh_run != 8'h00) begin
         sh_len <= sh_run;
         sh_run <= 8'h00;
      end
   end

   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   // request held until the rising edge that samples pready high; answer taken there
   task xfer(input logic w, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      rd = prdata;
      se = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task conv(input int ch);
      logic [31:0] w;
      logic [9:0] e;
      int n;
      w = 32'h28 | ch | (ch % 2 ? 32'h40 : 32'h0);
      e = lvl[ch] > 11'h3FF ? 10'h3FF : lvl[ch][9:0];
      xfer(1, 12'h3CC, w, d);
      xfer(1, 12'h3CC, w ^ 32'h1, d);
      @(negedge pclk);
      chk("channel", ch, selected_analog_input);
      chk("halt", ch % 2, cpu_halt);
      chk("other irq busy", ch % 2 == 0, other_irq_out);
      xfer(0, 12'h3CC, 0, d);
      chk("busy", 1, d[3]);
      n = 0;
      do begin xfer(0, 12'h3CC, 0, d); n++; end while (d[3] === 1'b1 && n < 300);
      chk("busy cleared", 0, d[3]);
      chk("done flag", 1, d[4]);
      repeat (4) @(negedge pclk);
      chk("conv irq", 1, conv_irq);
      chk("other irq after", 1, other_irq_out);
      xfer(0, 12'h3D4, 0, d);
      chk("result high", e[9:2], d);
      xfer(0, 12'h3D0, 0, d);
      chk("result low", ch % 2 ? e[1:0] : 0, d);
      xfer(1, 12'h3CC, 32'h20, d);
      repeat (2) @(negedge pclk);
      chk("irq rearm", 0, conv_irq);
   endtask
   task results;
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   initial begin
      repeat (20000) @(posedge pclk);
      err_total++;
      results();
   end
   initial begin
      presetn       <= 1'b0;
      psel          <= 1'b0;
      penable       <= 1'b0;
      pwrite        <= 1'b0;
      paddr         <= 12'h000;
      pwdata        <= 32'h0;
      other_irq_req <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 6; i++) begin xfer(0, 12'(12'h3C8 + 4 * i), 0, d); chk("reset value", 0, d); end
      xfer(0, 12'h000, 0, d);
      chk("unmapped", 1, se);
      xfer(1, 12'h3D8, 32'hDF, d);
      repeat (2) @(negedge pclk);
      chk("pin config", 8'hDF, analog_pin_config_out);
      xfer(1, 12'h3DC, 32'h2, d);
      xfer(1, 12'h3C8, 32'h3, d);
      xfer(1, 12'h3CC, 32'h20, d);
      repeat (2) @(negedge pclk);
      chk("powered", 1, converter_powered);
      repeat (80) @(posedge pclk);
      other_irq_req <= 1'b1;
      xfer(1, 12'h3CC, 32'h2D, d);
      xfer(0, 12'h3CC, 0, d);
      chk("start ignored", 0, d[4:3]);
      for (int i = 0; i < 8; i++) if (i != 5) conv(i);
      chk("sample clocks", 6, sh_len);
      // standby during the sample phase of a conversion: no busy, no done, channel kept
      xfer(1, 12'h3CC, 32'h2A, d);
      xfer(1, 12'h3CC, 32'h02, d);
      xfer(0, 12'h3CC, 0, d);
      chk("standby abort", 32'h02, d);
      chk("standby powered", 0, converter_powered);
      xfer(1, 12'h3CC, 32'h20, d);
      repeat (80) @(posedge pclk);
      xfer(1, 12'h3C8, 32'h0, d);
      conv(3);
      chk("sample clocks div64", 64, sh_len);
      results();
   end
endmodule
